// *** upc_pkg.sv ***
package upc_pkg;
  // ==========================================================
  // Mask byte positions
  localparam int BYTE_SEC_LSB = 0;
  localparam int BYTE_GP_LSB = 8;
  localparam int BYTE_LE_LSB = 16;
  localparam int BYTE_SYS_LSB = 24;
  // ==========================================================
  // Option bit indices, byte * 8 + bit
  localparam logic [4:0] OPT_READ_KEY = 5'h00;
  localparam logic [4:0] OPT_PRIV_KEY = 5'h01;
  localparam logic [4:0] OPT_WRAP_KEY = 5'h02;
  localparam logic [4:0] OPT_SEC_MASK = 5'h04;
  localparam logic [4:0] OPT_PRI_PIN = 5'h06;
  localparam logic [4:0] OPT_SEC_PIN = 5'h07;
  localparam logic [4:0] OPT_GP_UNPAIR = 5'h0d;
  localparam logic [4:0] OPT_SYS_COMM = 5'h18;
  localparam logic [4:0] OPT_SYS_FRST = 5'h19;
  // ==========================================================
  // Reset values, bytes ordered system, radio, green power, security
  localparam logic [31:0] PRI_MASK_RST = 32'h333f37d7;
  localparam logic [31:0] SEC_MASK_RST = 32'h333f3787;
  localparam logic [31:0] RSV_MASK = 32'hccc0c828;
  localparam logic [31:0] PIN_RST = 32'h00000000;
  localparam logic [31:0] CTR_RST = 32'h00000000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // ==========================================================
  // Outcome nibbles
  localparam logic [3:0] OUT_OK = 4'h3;
  localparam logic [3:0] OUT_BUSY = 4'h5;
  localparam logic [3:0] OUT_PIN = 4'h7;
  localparam logic [3:0] OUT_PERM = 4'h9;
  localparam logic [3:0] OUT_PARAM = 4'hb;
  // ==========================================================
  // Actuations counted before the one that completes a request
  localparam logic [2:0] ACT_LAST = 3'h1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    K_UPDATE = 2'h0,
    K_COMM = 2'h1,
    K_FRST = 2'h2,
    K_UNPAIR = 2'h3
  } upc_kind_t;
  typedef enum logic {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } upc_state_t;
endpackage : upc_pkg

// *** upc_checker.sv ***
`timescale 1ns/100ps
// Overview of operation
// R1: Two masks, bytes security, gp, radio, system
// R2: Option allowed only when own bit set
// R3: Primary clears secondary bits to withdraw options
// R4: Secondary mask written by primary only
// R5: Security byte keys, masks and PIN bits
// R6: Reserved bits never permit, read zero
// R7: Green power byte option bits
// R8: Low energy radio byte option bits
// R9: System byte option bits
// R10: Non-security option bits set after defaults
// R11: Two separate 32-bit replay counters
// R12: Counter register shows selected protocol counter
// R13: Status byte holds latest request outcome
// R14: Status code outcome nibble, requester nibble
// R15: In progress until actuations, then success
// R16: Wrong PIN gives PIN error
// R17: Missing mask bit gives permission error
// R18: Invalid parameter gives parameter error
// R19: Errors change nothing but status
module upc_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request from the contactless side
  input wire logic req_valid,
  input wire logic req_user,
  input wire upc_pkg::upc_kind_t req_kind,
  input wire logic [4:0] req_option,
  input wire logic [31:0] req_pin,
  input wire logic [31:0] req_data,
  input wire logic req_param_ok,
  output logic req_ready,
  // Asynchronous pins
  input wire logic harvest_pin,
  input wire logic proto_le_pin,
  // Replay counter steps
  input wire logic le_ctr_step,
  input wire logic gp_ctr_step,
  // Registers
  output logic [31:0] primary_user_permission_mask,
  output logic [31:0] secondary_user_permission_mask,
  output logic [31:0] active_replay_counter,
  output logic [7:0] request_outcome,
  // Executed request
  output logic apply_pulse,
  output upc_pkg::upc_kind_t apply_kind,
  output logic [4:0] apply_option,
  output logic [31:0] apply_data
);
  // ==========================================================
  // Pin synchronisers
  logic harv_s1_q, harv_s2_q, harv_s3_q;
  logic le_s1_q, le_s2_q;
  logic harv_s1_d, harv_s2_d, harv_s3_d, le_s1_d, le_s2_d;
  logic act_pulse;

  always_comb begin
    harv_s1_d = harvest_pin;
    harv_s2_d = harv_s1_q;
    harv_s3_d = harv_s2_q;
    le_s1_d = proto_le_pin;
    le_s2_d = le_s1_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      harv_s1_q <= 1'b0;
      harv_s2_q <= 1'b0;
      harv_s3_q <= 1'b0;
      le_s1_q <= 1'b0;
      le_s2_q <= 1'b0;
    end else begin
      harv_s1_q <= harv_s1_d;
      harv_s2_q <= harv_s2_d;
      harv_s3_q <= harv_s3_d;
      le_s1_q <= le_s1_d;
      le_s2_q <= le_s2_d;
    end
  end

  // Edge taken after the second stage only
  assign act_pulse = harv_s2_q & ~harv_s3_q;

  // ==========================================================
  // State
  upc_pkg::upc_state_t state_q, state_d;
  logic [31:0] pmask_q, pmask_d, smask_q, smask_d;
  logic [31:0] ppin_q, ppin_d, spin_q, spin_d;
  logic [31:0] le_ctr_q, le_ctr_d, gp_ctr_q, gp_ctr_d;
  logic [31:0] act_ctr_q, act_ctr_d;
  logic [7:0] status_q, status_d;
  logic [2:0] acts_q, acts_d;
  logic hold_user_q, hold_user_d;
  upc_pkg::upc_kind_t hold_kind_q, hold_kind_d;
  logic [4:0] hold_opt_q, hold_opt_d;
  logic [31:0] hold_data_q, hold_data_d;
  logic apply_q, apply_d;
  logic ready_q, ready_d;

  // ==========================================================
  // Request checks
  logic req_take, pin_ok, perm_ok, exec;
  logic [31:0] own_mask;
  logic [4:0] gate_opt;
  logic [3:0] req_low, hold_low;

  assign req_take = req_valid & (state_q == upc_pkg::S_IDLE);
  assign own_mask = req_user ? smask_q : pmask_q; // R2
  assign pin_ok = (req_pin == (req_user ? spin_q : ppin_q)); // R16
  assign req_low = {req_user, 3'({1'b0, req_kind} + 3'h1)}; // R14
  assign hold_low = {hold_user_q, 3'({1'b0, hold_kind_q} + 3'h1)};
  assign exec = (state_q == upc_pkg::S_WAIT) & act_pulse
    & (acts_q == upc_pkg::ACT_LAST); // R15

  always_comb begin
    case (req_kind)
      upc_pkg::K_COMM: gate_opt = upc_pkg::OPT_SYS_COMM; // R9
      upc_pkg::K_FRST: gate_opt = upc_pkg::OPT_SYS_FRST; // R9
      upc_pkg::K_UNPAIR: gate_opt = upc_pkg::OPT_GP_UNPAIR; // R7
      default: gate_opt = req_option; // R5 R7 R8 R9
    endcase
  end

  // Reserved bits gate nothing, and only the primary user may
  // reach the secondary mask whatever its own bit says
  assign perm_ok = own_mask[gate_opt] & ~upc_pkg::RSV_MASK[gate_opt]
    & ~(req_user & (req_kind == upc_pkg::K_UPDATE)
    & (req_option == upc_pkg::OPT_SEC_MASK)); // R4 R6 R17

  always_comb begin
    state_d = state_q;
    pmask_d = pmask_q;
    smask_d = smask_q;
    ppin_d = ppin_q;
    spin_d = spin_q;
    status_d = status_q;
    acts_d = acts_q;
    hold_user_d = hold_user_q;
    hold_kind_d = hold_kind_q;
    hold_opt_d = hold_opt_q;
    hold_data_d = hold_data_q;
    apply_d = 1'b0;
    le_ctr_d = le_ctr_q + {31'h0, le_ctr_step}; // R11
    gp_ctr_d = gp_ctr_q + {31'h0, gp_ctr_step}; // R11
    act_ctr_d = le_s2_q ? le_ctr_q : gp_ctr_q; // R12
    case (state_q)
      upc_pkg::S_IDLE: begin
        if (req_take) begin
          // Errors touch only the status byte
          if (!pin_ok) begin
            status_d = {upc_pkg::OUT_PIN, req_low}; // R16 R19
          end else if (!perm_ok) begin
            status_d = {upc_pkg::OUT_PERM, req_low}; // R17 R19
          end else if (!req_param_ok) begin
            status_d = {upc_pkg::OUT_PARAM, req_low}; // R18 R19
          end else begin
            status_d = {upc_pkg::OUT_BUSY, req_low}; // R13 R15
            state_d = upc_pkg::S_WAIT;
            acts_d = 3'h0;
            hold_user_d = req_user;
            hold_kind_d = req_kind;
            hold_opt_d = req_option;
            hold_data_d = req_data;
          end
        end
      end
      upc_pkg::S_WAIT: begin
        if (act_pulse) begin
          acts_d = 3'(acts_q + 3'h1);
        end
        if (exec) begin
          state_d = upc_pkg::S_IDLE;
          status_d = {upc_pkg::OUT_OK, hold_low}; // R13 R15
          apply_d = 1'b1;
          if (hold_kind_q == upc_pkg::K_FRST) begin
            pmask_d = upc_pkg::PRI_MASK_RST; // R10
            smask_d = upc_pkg::SEC_MASK_RST; // R10
            ppin_d = upc_pkg::PIN_RST;
            spin_d = upc_pkg::PIN_RST;
          end else if (hold_kind_q == upc_pkg::K_UPDATE) begin
            case (hold_opt_q)
              upc_pkg::OPT_SEC_MASK:
                smask_d = hold_data_q & ~upc_pkg::RSV_MASK; // R3 R6
              upc_pkg::OPT_PRI_PIN: ppin_d = hold_data_q;
              upc_pkg::OPT_SEC_PIN: spin_d = hold_data_q; // R4
              default: smask_d = smask_q;
            endcase
          end
        end
      end
      default: state_d = upc_pkg::S_IDLE;
    endcase
    // Ready is registered so the port comes straight from a flop
    ready_d = (state_d == upc_pkg::S_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= upc_pkg::S_IDLE;
      pmask_q <= upc_pkg::PRI_MASK_RST; // R1 R5 R10
      smask_q <= upc_pkg::SEC_MASK_RST; // R1 R5 R10
      ppin_q <= upc_pkg::PIN_RST;
      spin_q <= upc_pkg::PIN_RST;
      le_ctr_q <= upc_pkg::CTR_RST;
      gp_ctr_q <= upc_pkg::CTR_RST;
      act_ctr_q <= upc_pkg::CTR_RST;
      status_q <= upc_pkg::STATUS_RST;
      acts_q <= 3'h0;
      hold_user_q <= 1'b0;
      hold_kind_q <= upc_pkg::K_UPDATE;
      hold_opt_q <= 5'h00;
      hold_data_q <= 32'h00000000;
      apply_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pmask_q <= pmask_d;
      smask_q <= smask_d;
      ppin_q <= ppin_d;
      spin_q <= spin_d;
      le_ctr_q <= le_ctr_d;
      gp_ctr_q <= gp_ctr_d;
      act_ctr_q <= act_ctr_d;
      status_q <= status_d;
      acts_q <= acts_d;
      hold_user_q <= hold_user_d;
      hold_kind_q <= hold_kind_d;
      hold_opt_q <= hold_opt_d;
      hold_data_q <= hold_data_d;
      apply_q <= apply_d;
      ready_q <= ready_d;
    end
  end

  // ==========================================================
  // Outputs
  assign req_ready = ready_q;
  assign primary_user_permission_mask = pmask_q;
  assign secondary_user_permission_mask = smask_q;
  assign active_replay_counter = act_ctr_q;
  assign request_outcome = status_q;
  assign apply_pulse = apply_q;
  assign apply_kind = hold_kind_q;
  assign apply_option = hold_opt_q;
  assign apply_data = hold_data_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_pin_err;
    req_take && !pin_ok |=> status_q == {upc_pkg::OUT_PIN, $past(req_low)};
  endproperty
  a_pin_err: assert property (p_pin_err) // R16
    else $error("wrong PIN not reported");

  property p_perm_err;
    req_take && pin_ok && !perm_ok
      |=> status_q[7:4] == upc_pkg::OUT_PERM;
  endproperty
  a_perm_err: assert property (p_perm_err) // R17
    else $error("missing permission not reported");

  property p_param_err;
    req_take && pin_ok && perm_ok && !req_param_ok
      |=> status_q[7:4] == upc_pkg::OUT_PARAM && state_q == upc_pkg::S_IDLE;
  endproperty
  a_param_err: assert property (p_param_err) // R18
    else $error("bad parameter not reported");

  property p_err_keep;
    req_take && !(pin_ok && perm_ok && req_param_ok)
      |=> $stable(smask_q) && $stable(ppin_q) && $stable(spin_q)
      && !apply_q;
  endproperty
  a_err_keep: assert property (p_err_keep) // R19
    else $error("error request changed state");

  property p_busy_then_ok;
    exec |=> status_q == {upc_pkg::OUT_OK, $past(hold_low)} && apply_q
      ##1 !apply_q;
  endproperty
  a_busy_then_ok: assert property (p_busy_then_ok) // R15
    else $error("completion not reported");

  property p_in_prog;
    req_take && pin_ok && perm_ok && req_param_ok
      |=> status_q[7:4] == upc_pkg::OUT_BUSY && state_q == upc_pkg::S_WAIT;
  endproperty
  a_in_prog: assert property (p_in_prog) // R15
    else $error("accepted request not in progress");

  property p_rsv_zero;
    ((pmask_q | smask_q) & upc_pkg::RSV_MASK) == 32'h00000000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // R6
    else $error("reserved mask bit set");

  property p_sec_mask_owner;
    req_take && req_user && req_kind == upc_pkg::K_UPDATE
      && req_option == upc_pkg::OPT_SEC_MASK && pin_ok
      |=> status_q[7:4] == upc_pkg::OUT_PERM;
  endproperty
  a_sec_mask_owner: assert property (p_sec_mask_owner) // R4
    else $error("secondary wrote its own mask");

  property p_ctr_view;
    ##1 act_ctr_q == $past(le_s2_q ? le_ctr_q : gp_ctr_q);
  endproperty
  a_ctr_view: assert property (p_ctr_view) // R12
    else $error("wrong counter shown");

  c_pin_err: cover property (req_take && !pin_ok);
  c_success: cover property (exec);
  c_sec_update: cover property (exec && hold_user_q
    && hold_kind_q == upc_pkg::K_UPDATE);
  c_frst: cover property (exec && hold_kind_q == upc_pkg::K_FRST);
endmodule : upc_checker

// *** upc_reader.sv ***
`timescale 1ns/100ps
// ====================
// Contactless reader acting for one user at a time
module upc_reader (
  // Clock and handshake
  input wire logic core_clk,
  input wire logic req_ready,
  // Request lines
  output logic req_valid,
  output logic req_user,
  output upc_pkg::upc_kind_t req_kind,
  output logic [4:0] req_option,
  output logic [31:0] req_pin,
  output logic [31:0] req_data,
  output logic req_param_ok
);
  initial begin
    req_valid = 1'b0;
    req_user = 1'b0;
    req_kind = upc_pkg::K_UPDATE;
    req_option = 5'h00;
    req_pin = 32'h00000000;
    req_data = 32'h00000000;
    req_param_ok = 1'b1;
  end

  // Holds the request until it is taken or the tries run out
  task automatic send(input logic u, input upc_pkg::upc_kind_t k,
    input logic [4:0] o, input logic [31:0] p, input logic [31:0] d,
    input logic ok, input int tries, output logic taken);
    int n;
    taken = 1'b0;
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_user = u;
    req_kind = k;
    req_option = o;
    req_pin = p;
    req_data = d;
    req_param_ok = ok;
    // Ready is read while settled, then the edge that takes it passes
    for (n = 0; n < tries && !taken; n++) begin
      taken = (req_ready === 1'b1);
      @(posedge core_clk);
      #1;
    end
    req_valid = 1'b0;
    // Released lines other than req_kind are scrambled so nothing leans on stale values
    req_user = ~u;
    req_option = ~o;
    req_pin = ~p;
    req_data = ~d;
    req_param_ok = ~ok;
  endtask : send
endmodule : upc_reader

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  // ====================
  // Pins
  logic core_clk, rst, req_valid, req_user, req_param_ok, req_ready;
  upc_pkg::upc_kind_t req_kind, apply_kind;
  logic [4:0] req_option, apply_option;
  logic [31:0] req_pin, req_data, pmask, smask, ctr, apply_data;
  logic [7:0] outcome;
  logic harvest_pin, proto_le_pin, le_ctr_step, gp_ctr_step, apply_pulse, tk;
  int failures, n_checks, k, n_apply;

  upc_checker upc_checker_i (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req_user(req_user), .req_kind(req_kind),
    .req_option(req_option), .req_pin(req_pin), .req_data(req_data),
    .req_param_ok(req_param_ok), .req_ready(req_ready),
    .harvest_pin(harvest_pin), .proto_le_pin(proto_le_pin),
    .le_ctr_step(le_ctr_step), .gp_ctr_step(gp_ctr_step),
    .primary_user_permission_mask(pmask),
    .secondary_user_permission_mask(smask),
    .active_replay_counter(ctr), .request_outcome(outcome),
    .apply_pulse(apply_pulse), .apply_kind(apply_kind),
    .apply_option(apply_option), .apply_data(apply_data));
  upc_reader upc_reader_i (.core_clk(core_clk), .req_ready(req_ready),
    .req_valid(req_valid), .req_user(req_user), .req_kind(req_kind),
    .req_option(req_option), .req_pin(req_pin), .req_data(req_data),
    .req_param_ok(req_param_ok));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Completion pulses counted mid-cycle, where they are settled
  always @(negedge core_clk) begin
    if (apply_pulse === 1'b1) n_apply++;
  end

  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic req(input logic u, input upc_pkg::upc_kind_t kd,
    input logic [4:0] o, input logic [31:0] p, input logic [31:0] d,
    input logic ok, input logic [7:0] exp);
    upc_reader_i.send(u, kd, o, p, d, ok, 20, tk);
    chk({31'h0, tk}, 32'h1);
    if (tk !== 1'b1) finish_test();
    @(posedge core_clk);
    #1;
    chk({24'h0, outcome}, {24'h0, exp});
  endtask : req

  // Two actuations; still busy after the first, done after the second
  task automatic act2(input logic [3:0] lo);
    int n;
    int a0;
    a0 = n_apply;
    for (n = 0; n < 2; n++) begin
      chk({24'h0, outcome}, {24'h0, 4'h5, lo});
      @(posedge core_clk);
      #1;
      harvest_pin = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      harvest_pin = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
    end
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 20) begin
      failures++;
      finish_test();
    end
    chk({24'h0, outcome}, {24'h0, 4'h3, lo});
    chk(n_apply - a0, 32'h1);
    chk({30'h0, apply_kind}, {30'h0, 2'(lo[2:0] - 3'h1)});
  endtask : act2

  task automatic pulse(input logic le);
    @(posedge core_clk);
    #1;
    le_ctr_step = le;
    gp_ctr_step = ~le;
    @(posedge core_clk);
    #1;
    le_ctr_step = 1'b0;
    gp_ctr_step = 1'b0;
  endtask : pulse

  // ====================
  // Sequence
  initial begin
    rst = 1'b1;
    harvest_pin = 1'b0;
    proto_le_pin = 1'b1;
    le_ctr_step = 1'b0;
    gp_ctr_step = 1'b0;
    failures = 0;
    n_checks = 0;
    n_apply = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk(pmask, 32'h333f37d7);
    chk(smask, 32'h333f3787);
    chk(pmask & 32'hccc0c828, 32'h0);
    chk({24'h0, outcome}, 32'h0);
    repeat (3) pulse(1'b1);
    pulse(1'b0);
    repeat (6) @(posedge core_clk);
    #1;
    chk(ctr, 32'h3);
    proto_le_pin = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    chk(ctr, 32'h1);
    req(1'b1, upc_pkg::K_UPDATE, 5'h06, 0, 5, 1'b1, 8'h99);
    req(1'b0, upc_pkg::K_UPDATE, 5'h00, 7, 1, 1'b1, 8'h71);
    req(1'b0, upc_pkg::K_UPDATE, 5'h01, 0, 1, 1'b0, 8'hb1);
    chk(smask, 32'h333f3787);
    req(1'b0, upc_pkg::K_UPDATE, 5'h04, 0, 32'hff7f, 1'b1, 8'h51);
    upc_reader_i.send(1'b0, upc_pkg::K_COMM, 5'h00, 0, 0, 1'b1, 1, tk);
    chk({31'h0, tk}, 32'h0);
    act2(4'h1);
    chk(apply_data, 32'hff7f);
    chk(smask, 32'h00003757);
    chk({27'h0, apply_option}, 32'h4);
    req(1'b1, upc_pkg::K_UPDATE, 5'h10, 0, 0, 1'b1, 8'h99);
    req(1'b1, upc_pkg::K_UPDATE, 5'h07, 0, 1, 1'b1, 8'h99);
    req(1'b1, upc_pkg::K_COMM, 5'h00, 0, 0, 1'b1, 8'h9a);
    req(1'b1, upc_pkg::K_UPDATE, 5'h04, 0, 0, 1'b1, 8'h99);
    req(1'b0, upc_pkg::K_UPDATE, 5'h07, 0, 32'h1234, 1'b1, 8'h51);
    act2(4'h1);
    req(1'b1, upc_pkg::K_UPDATE, 5'h08, 0, 0, 1'b1, 8'h79);
    req(1'b1, upc_pkg::K_UPDATE, 5'h08, 32'h1234, 0, 1'b1, 8'h59);
    act2(4'h9);
    req(1'b1, upc_pkg::K_UPDATE, 5'h0b, 32'h1234, 0, 1'b1, 8'h99);
    for (k = 1; k < 4; k++) begin
      req(1'b0, upc_pkg::upc_kind_t'(k), 5'h00, 0, 0, 1'b1,
        {4'h5, 4'(k + 1)});
      act2(4'(k + 1));
    end
    chk(smask, 32'h333f3787);
    req(1'b1, upc_pkg::K_UNPAIR, 5'h00, 0, 0, 1'b1, 8'h5c);
    act2(4'hc);
    finish_test();
  end
endmodule : tb
